/* bdio_pkg.sv */
// package of constants for the buffered 12-channel digital input/output port
package bdio_pkg;
  localparam int WIDTH = 12;
  // io opcode fields: 6 dd f, device code octal 50..57
  localparam logic [2:0] IO_PREFIX = 3'h6;
  localparam logic [5:0] DEV_CODE_MIN = 6'h28;
  localparam logic [5:0] DEV_CODE_MAX = 6'h2F;
  localparam logic [5:0] DEV_CODE_RESET = 6'h28;
  localparam int OP_HI = 11;
  localparam int OP_LO = 9;
  localparam int DEV_HI = 8;
  localparam int DEV_LO = 3;
  localparam int FN_HI = 2;
  // function codes
  localparam logic [2:0] FN_IRQ_DISABLE = 3'h0;
  localparam logic [2:0] FN_IRQ_ENABLE = 3'h1;
  localparam logic [2:0] FN_SKIP = 3'h2;
  localparam logic [2:0] FN_IN_CLEAR = 3'h3;
  localparam logic [2:0] FN_IN_READ = 3'h4;
  localparam logic [2:0] FN_OUT_CLEAR = 3'h5;
  localparam logic [2:0] FN_OUT_SET = 3'h6;
  localparam logic [2:0] FN_OUT_READ = 3'h7;
  // least input low time and the cycles it covers at 40 MHz
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MIN_LOW_NS = 50;
  localparam int MIN_LOW_CYC = (MIN_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] REG_RESET = 12'h000;
endpackage

/* bdio_port.sv */
// buffered 12-channel digital input/output port, device side
`timescale 1ns/1ps
`default_nettype none
module bdio_port #(
  parameter int WIDTH = bdio_pkg::WIDTH
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic bus_init_i,
  input wire logic [5:0] dev_code_i,
  input wire logic io_strobe_i,
  input wire logic [11:0] io_instr_i,
  input wire logic [WIDTH-1:0] acc_i,
  output logic [WIDTH-1:0] acc_data_o,
  output logic acc_load_o,
  output logic skip_o,
  output logic irq_o,
  input wire logic [WIDTH-1:0] in_lines_n_i,
  input wire logic [WIDTH-1:0] level_mode_i,
  input wire logic [WIDTH-1:0] event_enable_i,
  output logic [WIDTH-1:0] out_lines_n_o,
  output logic irq_enable_o
);
  // the instruction and accumulator paths are fixed at 12 bits, so refuse other widths
  generate
    if (WIDTH != bdio_pkg::WIDTH) begin : g_bad_width
      $error("bdio_port: width must equal the accumulator width");
    end
  endgenerate

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // device code strap, registered every clock after reset release
  logic [5:0] dev_code;
  logic dev_valid;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      dev_code <= bdio_pkg::DEV_CODE_RESET;
    end else begin
      dev_code <= dev_code_i;
    end
  end
  // an out-of-range strap falls back to the factory code
  assign dev_valid = (dev_code >= bdio_pkg::DEV_CODE_MIN) &&
                     (dev_code <= bdio_pkg::DEV_CODE_MAX);

  // ==========================================================
  // instruction decode
  wire logic [5:0] active_code;
  wire logic selected;
  wire logic [2:0] fn;
  wire logic op_irq_disable;
  wire logic op_irq_enable;
  wire logic op_skip;
  wire logic op_in_clear;
  wire logic op_in_read;
  wire logic op_out_clear;
  wire logic op_out_set;
  wire logic op_out_read;
  assign active_code = dev_valid ? dev_code : bdio_pkg::DEV_CODE_RESET;
  assign selected = io_strobe_i &&
      (io_instr_i[bdio_pkg::OP_HI:bdio_pkg::OP_LO] == bdio_pkg::IO_PREFIX) &&
      (io_instr_i[bdio_pkg::DEV_HI:bdio_pkg::DEV_LO] == active_code);
  assign fn = io_instr_i[bdio_pkg::FN_HI:0];
  assign op_irq_disable = selected && (fn == bdio_pkg::FN_IRQ_DISABLE);
  assign op_irq_enable = selected && (fn == bdio_pkg::FN_IRQ_ENABLE);
  assign op_skip = selected && (fn == bdio_pkg::FN_SKIP);
  assign op_in_clear = selected && (fn == bdio_pkg::FN_IN_CLEAR);
  assign op_in_read = selected && (fn == bdio_pkg::FN_IN_READ);
  assign op_out_clear = selected && (fn == bdio_pkg::FN_OUT_CLEAR);
  assign op_out_set = selected && (fn == bdio_pkg::FN_OUT_SET);
  assign op_out_read = selected && (fn == bdio_pkg::FN_OUT_READ);

  // ==========================================================
  // output register
  logic [WIDTH-1:0] out_reg;
  wire logic [WIDTH-1:0] next_out_reg;
  // set then clear: one instruction at a time, so no overlap matters
  assign next_out_reg = op_out_set ? (out_reg | acc_i) :
                        op_out_clear ? (out_reg & ~acc_i) :
                        out_reg;
  // init leaves contents alone; software clears them itself
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= bdio_pkg::REG_RESET;
    end else begin
      out_reg <= next_out_reg;
    end
  end
  // lines are low for true and move only with the register
  assign out_lines_n_o = ~out_reg;

  // ==========================================================
  // input capture, one cell per channel
  logic [WIDTH-1:0] in_prev;
  logic [WIDTH-1:0] in_latch;
  wire logic [WIDTH-1:0] in_true;
  wire logic [WIDTH-1:0] in_view;
  assign in_true = ~in_lines_n_i;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_in
      wire logic fall;
      wire logic clr;
      // a falling edge seen at one sample is caught; 50 ns spans two samples
      assign fall = in_prev[gi] && !in_lines_n_i[gi];
      assign clr = op_in_clear && acc_i[gi];
      always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
          in_prev[gi] <= 1'b1;
          in_latch[gi] <= 1'b0;
        end else begin
          in_prev[gi] <= in_lines_n_i[gi];
          // a new edge wins over a clear in the same cycle, so no event is lost
          if (fall) begin
            in_latch[gi] <= 1'b1;
          end else if (clr) begin
            in_latch[gi] <= 1'b0;
          end
        end
      end
      // level mode bypasses the latch entirely
      assign in_view[gi] = level_mode_i[gi] ? in_true[gi] : in_latch[gi];
    end
  endgenerate

  // ==========================================================
  // event flag, interrupt enable, skip and interrupt
  logic irq_en;
  wire logic event_flag;
  assign event_flag = |(in_view & event_enable_i);
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= 1'b0;
    end else if (bus_init_i || op_irq_disable) begin
      irq_en <= 1'b0;
    end else if (op_irq_enable) begin
      irq_en <= 1'b1;
    end
  end
  assign irq_o = irq_en && event_flag;
  assign irq_enable_o = irq_en;
  assign skip_o = op_skip && event_flag;

  // ==========================================================
  // read data back to the accumulator
  wire logic [WIDTH-1:0] next_acc_data;
  assign next_acc_data = op_out_read ? out_reg :
                         op_in_read ? in_view :
                         acc_data_o;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      acc_data_o <= bdio_pkg::REG_RESET;
    end else begin
      acc_data_o <= next_acc_data;
    end
  end
  // load strobe is combinational, data follows one clock later
  assign acc_load_o = op_out_read || op_in_read;
endmodule
`default_nettype wire

/* bdio_port_assertions.sv */
// checker of the digital port behaviour at its ports
`timescale 1ns/1ps
`default_nettype none
module bdio_port_assertions (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic bus_init_i,
  input wire logic [5:0] dev_code_i,
  input wire logic io_strobe_i,
  input wire logic [11:0] io_instr_i,
  input wire logic [11:0] acc_i,
  input wire logic [11:0] acc_data_o,
  input wire logic acc_load_o,
  input wire logic skip_o,
  input wire logic irq_o,
  input wire logic [11:0] out_lines_n_o,
  input wire logic irq_enable_o
);
  // ====
  // decode; a strap outside 50..57 octal falls back to 50
  wire [5:0] code = (dev_code_i < 6'h28 || dev_code_i > 6'h2F) ? 6'h28 : dev_code_i;
  wire sel = io_strobe_i && io_instr_i[11:9] == 3'h6 && io_instr_i[8:3] == code;
  wire [2:0] fn = io_instr_i[2:0];
  wire [11:0] outv = ~out_lines_n_o;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  AST_LOAD: assert property (acc_load_o == (sel && (fn == 3'h4 || fn == 3'h7)))
    else $error("load strobe");
  AST_SKIP: assert property (sel && fn == 3'h2 && irq_enable_o |-> skip_o == irq_o)
    else $error("skip");
  AST_SKIP_ONLY: assert property (skip_o |-> sel && fn == 3'h2)
    else $error("skip outside its instruction");
  AST_IRQ_GATE: assert property (!irq_enable_o |-> !irq_o)
    else $error("interrupt while disabled");
  AST_SET: assert property (sel && fn == 3'h6 |=> outv == ($past(outv) | $past(acc_i)))
    else $error("set");
  AST_CLR: assert property (sel && fn == 3'h5 |=> outv == ($past(outv) & ~$past(acc_i)))
    else $error("clear");
  AST_HOLD: assert property (!(sel && fn[2] && ^fn[1:0]) |=> $stable(out_lines_n_o))
    else $error("hold");
  AST_RDO: assert property (sel && fn == 3'h7 |=> acc_data_o == $past(outv))
    else $error("readback");
  AST_IEN: assert property (sel && fn == 3'h1 && !bus_init_i |=> irq_enable_o)
    else $error("enable");
  AST_IDIS: assert property ((sel && fn == 3'h0) || bus_init_i |=> !irq_enable_o)
    else $error("disable");
endmodule
bind bdio_port bdio_port_assertions u_chk (
  .clock_i(clock_i),
  .nrst_i(nrst_i),
  .bus_init_i(bus_init_i),
  .dev_code_i(dev_code_i),
  .io_strobe_i(io_strobe_i),
  .io_instr_i(io_instr_i),
  .acc_i(acc_i),
  .acc_data_o(acc_data_o),
  .acc_load_o(acc_load_o),
  .skip_o(skip_o),
  .irq_o(irq_o),
  .out_lines_n_o(out_lines_n_o),
  .irq_enable_o(irq_enable_o)
);
`default_nettype wire

/* bdio_lines_model.sv */
// external switches and event sources
`timescale 1ns/1ps
`default_nettype none
module bdio_lines_model (
  input wire logic clock_i,
  output logic [11:0] lines_n_o
);
  // ====
  // idle high through pull-ups; low means true
  initial lines_n_o = 12'hFFF;
  // two cycles low is the 50 ns minimum, the hardest case
  task automatic pulse(input logic [11:0] m, input int n);
    @(posedge clock_i) lines_n_o <= ~m;
    repeat (n) @(posedge clock_i);
    lines_n_o <= 12'hFFF;
  endtask
  task automatic hold(input logic [11:0] m);
    @(posedge clock_i) lines_n_o <= ~m;
  endtask
endmodule
`default_nettype wire

/* test_buffered_digital_io_12ch.sv */
// self-checking bench for the digital port
`timescale 1ns/1ps
`default_nettype none
module test_buffered_digital_io_12ch;
  localparam logic [5:0] DC = 6'h2B;
  logic clock_i = 1'b0, nrst_i = 1'b0, bus_init_i = 1'b0, io_strobe_i = 1'b0, ld, sk;
  logic [5:0] dev_code_i = DC;
  logic [11:0] io_instr_i = 12'h000, acc_i = 12'h000, level_mode_i = 12'h000;
  logic [11:0] event_enable_i = 12'hFFF;
  wire [11:0] acc_data_o, out_lines_n_o, in_lines_n_i;
  wire acc_load_o, skip_o, irq_o, irq_enable_o;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #12.5 clock_i = ~clock_i;
  bdio_port u_dut (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .bus_init_i(bus_init_i),
    .dev_code_i(dev_code_i),
    .io_strobe_i(io_strobe_i),
    .io_instr_i(io_instr_i),
    .acc_i(acc_i),
    .acc_data_o(acc_data_o),
    .acc_load_o(acc_load_o),
    .skip_o(skip_o),
    .irq_o(irq_o),
    .in_lines_n_i(in_lines_n_i),
    .level_mode_i(level_mode_i),
    .event_enable_i(event_enable_i),
    .out_lines_n_o(out_lines_n_o),
    .irq_enable_o(irq_enable_o)
  );
  bdio_lines_model u_lines (.clock_i(clock_i), .lines_n_o(in_lines_n_i));
  // ====
  // one instruction; same-cycle answers are caught before the strobe drops
  task automatic io(input logic [5:0] c, input logic [2:0] f, input logic [11:0] a);
    @(posedge clock_i);
    io_strobe_i <= 1'b1;
    io_instr_i <= {3'h6, c, f};
    acc_i <= a;
    #1 ld = acc_load_o;
    sk = skip_o;
    @(posedge clock_i);
    io_strobe_i <= 1'b0;
    #1;
  endtask
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard, tests need some sixty cycles
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    io(DC, 3'h5, 12'hFFF);
    io(DC, 3'h6, 12'h00F);
    chk("out", 12'hFF0, out_lines_n_o);
    io(DC, 3'h5, 12'h003);
    io(6'h2C, 3'h6, 12'hFFF);
    chk("out", 12'hFF3, out_lines_n_o);
    io(DC, 3'h7, 12'h000);
    chk("rdo", 12'h00C, acc_data_o);
    chk("ld", 12'h001, 12'(ld));
    $display("output test done");
    io(DC, 3'h3, 12'hFFF);
    @(posedge clock_i) event_enable_i <= 12'h000;
    u_lines.pulse(12'h005, 2);
    io(DC, 3'h2, 12'h000);
    chk("skip", 12'h000, 12'(sk));
    chk("ld", 12'h000, 12'(ld));
    io(DC, 3'h4, 12'h000);
    chk("rdi", 12'h005, acc_data_o);
    io(DC, 3'h3, 12'h001);
    io(DC, 3'h4, 12'h000);
    chk("rdi", 12'h004, acc_data_o);
    $display("input test done");
    @(posedge clock_i) event_enable_i <= 12'hFFF;
    io(DC, 3'h1, 12'h000);
    chk("irq", 12'h001, 12'(irq_o));
    io(DC, 3'h2, 12'h000);
    chk("skip", 12'h001, 12'(sk));
    io(DC, 3'h0, 12'h000);
    chk("irq", 12'h000, 12'(irq_o));
    io(DC, 3'h1, 12'h000);
    @(posedge clock_i) bus_init_i <= 1'b1;
    @(posedge clock_i) bus_init_i <= 1'b0;
    #1 chk("ien", 12'h000, 12'(irq_enable_o));
    chk("out", 12'hFF3, out_lines_n_o);
    $display("interrupt test done");
    @(posedge clock_i) level_mode_i <= 12'hFFF;
    u_lines.hold(12'h0F0);
    io(DC, 3'h4, 12'h000);
    chk("lvl", 12'h0F0, acc_data_o);
    u_lines.hold(12'h000);
    io(DC, 3'h4, 12'h000);
    chk("lvl", 12'h000, acc_data_o);
    $display("level test done");
    finish_test;
  end
endmodule
`default_nettype wire
